// ### testbench/sdic_host_model.sv
// Behavioural motion controller that drives the discrete input pins.
// Assumes the bench sets wanted levels right after a pclk edge.
`timescale 1ns/1ps
`default_nettype none
module sdic_host_model #(
  parameter int NP = 14
) (
  // Clock
  input wire logic pclk,
  // Wanted and driven levels
  input wire logic [NP-1:0] want,
  output logic [NP-1:0] pins
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Push-pull outputs, so every pin always shows a definite level.
  initial begin
    pins = '0;
    forever @(posedge pclk) pins <= want;
  end
endmodule : sdic_host_model
`default_nettype wire

// ### testbench/sdic_input_control_tb.sv
// Self-checking bench of the servo drive input control block.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sdic_params.svh"
module sdic_input_control_tb;
  import sdic_pkg::*;
  localparam int NP = 14;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [NP-1:0] want = '0;
  logic [NP-1:0] pins;
  logic fault_event = 1'b0;
  logic fb_step = 1'b0;
  logic fb_dir = 1'b0;
  logic servo_enabled, speed_loop_p_only, dir_reversed, speed_ref_zero;
  logic pulse_inhibit, fwd_run_allow, rev_run_allow, alarm_active;
  logic fwd_current_limit, rev_current_limit, homing_start;
  logic zero_position, regen_internal_sel;
  logic [1:0] int_speed_sel;
  sdic_mode_t active_mode;
  logic [15:0] position_error;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_tests = 0;
  int n_home = 0;
  logic [31:0] cfg_tab [6] = '{32'h0, 32'h81, 32'h103, 32'h22, 32'hE, 32'h5};
  logic [5:0] on_tab [6] = '{6'h20, 6'h10, 6'h08, 6'h01, 6'h05, 6'h00};

  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    if (homing_start === 1'b1) n_home <= n_home + 1;
  end

  sdic_host_model #(.NP(NP)) u_host (.pclk(pclk), .want(want), .pins(pins));

  sdic_input_control u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .servo_on_input(pins[0]), .multi_purpose_control_input(pins[1]),
    .forward_travel_limit(pins[2]), .reverse_travel_limit(pins[3]),
    .forward_torque_limit_input(pins[4]),
    .reverse_torque_limit_input(pins[5]),
    .alarm_release_input(pins[6]), .error_count_clear_input(pins[7]),
    .ref_pulse_input(pins[8]), .ref_dir_input(pins[9]),
    .general_input(pins[13:10]), .fault_event(fault_event),
    .fb_step(fb_step), .fb_dir(fb_dir), .servo_enabled(servo_enabled),
    .speed_loop_p_only(speed_loop_p_only), .dir_reversed(dir_reversed),
    .active_mode(active_mode), .speed_ref_zero(speed_ref_zero),
    .pulse_inhibit(pulse_inhibit), .fwd_run_allow(fwd_run_allow),
    .rev_run_allow(rev_run_allow), .fwd_current_limit(fwd_current_limit),
    .rev_current_limit(rev_current_limit), .int_speed_sel(int_speed_sel),
    .alarm_active(alarm_active), .homing_start(homing_start),
    .zero_position(zero_position), .regen_internal_sel(regen_internal_sel),
    .position_error(position_error)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // The slave sets its own pace, so the access phase waits for pready.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk

  // Pins pass a filter, so each level is held well past its latency.
  task automatic setp(input int i, input logic v);
    want[i] <= v;
    wt(8);
  endtask : setp

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    int h;
    wt(6);
    presetn <= 1'b1;
    check(regen_internal_sel, 32'h1);
    rchk(`SDIC_OFS_CFG, 32'h200);
    rchk(`SDIC_OFS_INT_MASK, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, `SDIC_OFS_CFG, 32'h0);
    wt(3);
    check(regen_internal_sel, 32'h0);
    setp(0, 1'b1);
    setp(2, 1'b1);
    setp(3, 1'b1);
    check({fwd_run_allow, rev_run_allow}, 32'h3);
    rchk(`SDIC_OFS_STATUS, 32'h0002_000D);
    apb(1'b1, `SDIC_OFS_INT_MASK, 32'h08);
    setp(2, 1'b0);
    check({fwd_run_allow, rev_run_allow, irq}, 32'h3);
    rchk(`SDIC_OFS_INT_STAT, 32'h08);
    setp(2, 1'b1);
    setp(3, 1'b0);
    check({fwd_run_allow, rev_run_allow, irq}, 32'h5);
    apb(1'b1, `SDIC_OFS_INT_STAT, 32'h3F);
    setp(3, 1'b1);
    for (i = 0; i < 6; i++) begin
      apb(1'b1, `SDIC_OFS_CFG, cfg_tab[i]);
      wt(3);
      check({speed_loop_p_only, dir_reversed, speed_ref_zero, pulse_inhibit,
             active_mode}, {4'h0, cfg_tab[i][4:3]});
      setp(1, 1'b1);
      check({speed_loop_p_only, dir_reversed, speed_ref_zero, pulse_inhibit,
             active_mode}, on_tab[i]);
      setp(1, 1'b0);
    end
    for (i = 0; i < 8; i++) begin
      if (i == 0) apb(1'b1, `SDIC_OFS_CFG, 32'h0);
      if (i == 4) apb(1'b1, `SDIC_OFS_CFG, 32'h80);
      setp(4, i[0]);
      setp(5, i[1]);
      if (i < 4) begin
        check({rev_current_limit, fwd_current_limit}, i[1:0]);
      end else begin
        check({int_speed_sel, rev_current_limit, fwd_current_limit},
              {i[1:0], 2'b00});
      end
    end
    setp(4, 1'b0);
    setp(5, 1'b0);
    apb(1'b1, `SDIC_OFS_INT_MASK, 32'h01);
    fault_event <= 1'b1;
    @(posedge pclk);
    fault_event <= 1'b0;
    wt(4);
    check({alarm_active, servo_enabled, irq}, 32'h5);
    setp(6, 1'b1);
    setp(6, 1'b0);
    check({alarm_active, servo_enabled}, 32'h1);
    rchk(`SDIC_OFS_INT_STAT, 32'h03);
    apb(1'b1, `SDIC_OFS_INT_STAT, 32'h03);
    wt(3);
    check(irq, 32'h0);
    apb(1'b1, `SDIC_OFS_CFG, 32'h08);
    for (i = 0; i < 3; i++) begin
      setp(8, 1'b1);
      setp(8, 1'b0);
    end
    check(position_error, 32'h3);
    rchk(`SDIC_OFS_ERRCNT, 32'h3);
    fb_step <= 1'b1;
    @(posedge pclk);
    fb_step <= 1'b0;
    wt(2);
    check(position_error, 32'h2);
    apb(1'b1, `SDIC_OFS_CFG, 32'h18);
    setp(7, 1'b1);
    check({active_mode, position_error}, {2'h3, 16'h2});
    apb(1'b1, `SDIC_OFS_CFG, 32'h08);
    setp(8, 1'b1);
    setp(8, 1'b0);
    check(position_error, 32'h0);
    setp(7, 1'b0);
    apb(1'b1, `SDIC_OFS_CFG, 32'hE);
    setp(1, 1'b1);
    setp(8, 1'b1);
    setp(8, 1'b0);
    check(position_error, 32'h0);
    setp(1, 1'b0);
    apb(1'b1, `SDIC_OFS_ALLOC_A, 32'h1);
    apb(1'b1, `SDIC_OFS_ALLOC_B, 32'h2);
    h = n_home;
    setp(10, 1'b1);
    wt(10);
    setp(10, 1'b0);
    check(n_home - h, 32'h1);
    check(zero_position, 32'h0);
    setp(11, 1'b1);
    check(zero_position, 32'h1);
    setp(11, 1'b0);
    check(zero_position, 32'h0);
    conclude();
  end
endmodule : sdic_input_control_tb
`default_nettype wire

// ### verilog/sdic_in_sync.sv
// Three-stage input synchroniser with a two-stage agreement filter.
// Assumes its inputs are asynchronous pins and pclk is free running.
`timescale 1ns/1ps
`default_nettype none
module sdic_in_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and filtered levels
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_level
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  if (W < 1) begin : g_bad_width
    $error("sdic_in_sync: W must be at least 1");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A level counts only once two stages agree, rejecting a short glitch.
  for (genvar i = 0; i < W; i++) begin : g_filter
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_level[i] <= 1'b0;
      end else if (stage2[i] == stage3[i]) begin
        pin_level[i] <= stage3[i];
      end
    end
  end
endmodule : sdic_in_sync
`default_nettype wire

// ### verilog/sdic_input_control.sv
// Discrete control-input handling of a servo drive, with an APB register file.
// Assumes one 20 MHz clock pclk, pins asynchronous, drive core on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "sdic_params.svh"
module sdic_input_control #(
  parameter int NGEN = 4,
  parameter int ERR_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Discrete pins, high means ON
  input wire logic servo_on_input,
  input wire logic multi_purpose_control_input,
  input wire logic forward_travel_limit,
  input wire logic reverse_travel_limit,
  input wire logic forward_torque_limit_input,
  input wire logic reverse_torque_limit_input,
  input wire logic alarm_release_input,
  input wire logic error_count_clear_input,
  input wire logic ref_pulse_input,
  input wire logic ref_dir_input,
  input wire logic [NGEN-1:0] general_input,
  // Drive core events
  input wire logic fault_event,
  input wire logic fb_step,
  input wire logic fb_dir,
  // Drive actions
  output logic servo_enabled,
  output logic speed_loop_p_only,
  output logic dir_reversed,
  output var sdic_pkg::sdic_mode_t active_mode,
  output logic speed_ref_zero,
  output logic pulse_inhibit,
  output logic fwd_run_allow,
  output logic rev_run_allow,
  output logic fwd_current_limit,
  output logic rev_current_limit,
  output logic [1:0] int_speed_sel,
  output logic alarm_active,
  output logic homing_start,
  output logic zero_position,
  output logic regen_internal_sel,
  output logic [ERR_W-1:0] position_error
);
  import sdic_pkg::*;

  // ----------------------------------------------------------------------
  // Pin indices and checks
  // ----------------------------------------------------------------------
  localparam int P_SON = 0;
  localparam int P_MP = 1;
  localparam int P_FWD = 2;
  localparam int P_REV = 3;
  localparam int P_PCL = 4;
  localparam int P_NCL = 5;
  localparam int P_ALM = 6;
  localparam int P_CLR = 7;
  localparam int P_REF = 8;
  localparam int P_DIR = 9;
  localparam int P_GEN = 10;
  localparam int NPIN = P_GEN + NGEN;

  // Allocation codes reach general inputs 1 to NGEN (at most 6), code 0 means unallocated.
  if (NGEN < 1 || NGEN > 6 || ERR_W < 2 || ERR_W > 32) begin : g_bad_param
    $error("sdic_input_control: NGEN 1..6 and ERR_W 2..32 only");
  end

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_prev;

  assign pin_raw = {general_input, ref_dir_input, ref_pulse_input,
                    error_count_clear_input, alarm_release_input,
                    reverse_torque_limit_input, forward_torque_limit_input,
                    reverse_travel_limit, forward_travel_limit,
                    multi_purpose_control_input, servo_on_input};

  sdic_in_sync #(.W(NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(pin_raw),
    .pin_level(pin_lvl)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_lvl;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  sdic_mp_func_t mp_sel;
  sdic_mode_t ctrl_mode;
  sdic_mode_t alt_mode;
  sdic_tl_func_t tl_sel;
  logic zclamp_en;
  logic [`SDIC_ALLOC_W-1:0] alloc_a;
  logic [`SDIC_ALLOC_W-1:0] alloc_b;
  logic [`SDIC_NUM_EV-1:0] int_stat;
  logic [`SDIC_NUM_EV-1:0] int_mask;
  logic [`SDIC_NUM_EV-1:0] events;
  logic [`SDIC_NUM_EV-1:0] next_int_stat;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_en;

  function automatic logic mp_is(input sdic_mp_func_t f);
    return mp_sel == f;
  endfunction : mp_is

  function automatic logic alloc_pick(input logic [`SDIC_ALLOC_W-1:0] sel,
                                      input logic [NPIN-1:0] pins);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NGEN; i++) begin
      if (int'(sel) == i + 1) begin
        hit = pins[P_GEN + i];
      end
    end
    return hit;
  endfunction : alloc_pick

  // A write lands only at the completing edge of the access phase.
  assign wr_en = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mp_sel <= SDIC_MP_PCTRL;
      ctrl_mode <= SDIC_SPEED;
      alt_mode <= SDIC_SPEED;
      tl_sel <= SDIC_TL_EXT;
      zclamp_en <= 1'b0;
      regen_internal_sel <= `SDIC_REGEN_RST;
      alloc_a <= `SDIC_ALLOC_RST;
      alloc_b <= `SDIC_ALLOC_RST;
      int_mask <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        `SDIC_OFS_CFG: begin
          mp_sel <= sdic_mp_func_t'(pwdata[`SDIC_CFG_MP_LSB +: 3]);
          ctrl_mode <= sdic_mode_t'(pwdata[`SDIC_CFG_MODE_LSB +: 2]);
          alt_mode <= sdic_mode_t'(pwdata[`SDIC_CFG_ALT_LSB +: 2]);
          tl_sel <= sdic_tl_func_t'(pwdata[`SDIC_CFG_TL_BIT]);
          zclamp_en <= pwdata[`SDIC_CFG_ZCLAMP_BIT];
          regen_internal_sel <= pwdata[`SDIC_CFG_REGEN_BIT];
        end
        `SDIC_OFS_ALLOC_A: alloc_a <= pwdata[`SDIC_ALLOC_LSB +: `SDIC_ALLOC_W];
        `SDIC_OFS_ALLOC_B: alloc_b <= pwdata[`SDIC_ALLOC_LSB +: `SDIC_ALLOC_W];
        `SDIC_OFS_INT_MASK: int_mask <= pwdata[`SDIC_NUM_EV-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Input decoding
  // ----------------------------------------------------------------------
  sdic_mode_t mode_now;
  logic mp_on;
  logic pin_block;
  logic clr_now;
  logic hom_lvl;
  logic hom_prev;
  logic zero_lvl;
  logic ref_take;
  logic [ERR_W-1:0] next_err;

  assign mp_on = pin_lvl[P_MP];
  assign mode_now = (mp_is(SDIC_MP_MODESW) && mp_on) ? alt_mode : ctrl_mode;
  assign pin_block = mode_now == SDIC_POSITION && mp_is(SDIC_MP_PINH) && mp_on;
  assign clr_now = mode_now == SDIC_POSITION && pin_lvl[P_CLR];
  assign hom_lvl = alloc_pick(alloc_a, pin_lvl);
  assign hom_prev = alloc_pick(alloc_a, pin_prev);
  assign zero_lvl = alloc_pick(alloc_b, pin_lvl);
  assign ref_take = mode_now == SDIC_POSITION && !pin_block &&
                    pin_lvl[P_REF] && !pin_prev[P_REF];

  // ----------------------------------------------------------------------
  // Drive actions
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mode <= SDIC_SPEED;
      speed_loop_p_only <= 1'b0;
      dir_reversed <= 1'b0;
      speed_ref_zero <= 1'b0;
      pulse_inhibit <= 1'b0;
    end else begin
      active_mode <= mode_now;
      speed_loop_p_only <= mp_is(SDIC_MP_PCTRL) && mp_on;
      dir_reversed <= mp_is(SDIC_MP_DIR) && tl_sel == SDIC_TL_INTSPD && mp_on;
      speed_ref_zero <= zclamp_en && mode_now == SDIC_SPEED &&
                        mp_is(SDIC_MP_ZCLAMP) && mp_on;
      pulse_inhibit <= pin_block;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_run_allow <= 1'b0;
      rev_run_allow <= 1'b0;
      fwd_current_limit <= 1'b0;
      rev_current_limit <= 1'b0;
      int_speed_sel <= 2'h0;
      homing_start <= 1'b0;
      zero_position <= 1'b0;
    end else begin
      fwd_run_allow <= pin_lvl[P_FWD];
      rev_run_allow <= pin_lvl[P_REV];
      fwd_current_limit <= tl_sel == SDIC_TL_EXT && pin_lvl[P_PCL];
      rev_current_limit <= tl_sel == SDIC_TL_EXT && pin_lvl[P_NCL];
      int_speed_sel <= (tl_sel == SDIC_TL_INTSPD) ?
                       {pin_lvl[P_NCL], pin_lvl[P_PCL]} : 2'h0;
      homing_start <= hom_lvl && !hom_prev;
      zero_position <= zero_lvl;
    end
  end

  // Fault wins over release so a fault in the same cycle is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_active <= 1'b0;
      servo_enabled <= 1'b0;
    end else begin
      if (fault_event) begin
        alarm_active <= 1'b1;
      end else if (pin_lvl[P_ALM] && !pin_prev[P_ALM]) begin
        alarm_active <= 1'b0;
      end
      servo_enabled <= pin_lvl[P_SON] && !alarm_active && !fault_event;
    end
  end

  // The count wraps; a saturating counter would hide runaway from software.
  always_comb begin
    next_err = position_error;
    if (ref_take) begin
      next_err = pin_lvl[P_DIR] ? next_err - 1'b1 : next_err + 1'b1;
    end
    if (fb_step) begin
      next_err = fb_dir ? next_err + 1'b1 : next_err - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_error <= '0;
    end else if (clr_now) begin
      position_error <= '0;
    end else begin
      position_error <= next_err;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    events = '0;
    events[`SDIC_EV_FAULT] = fault_event;
    events[`SDIC_EV_ALM_REL] = pin_lvl[P_ALM] && !pin_prev[P_ALM];
    events[`SDIC_EV_HOMING] = hom_lvl && !hom_prev;
    events[`SDIC_EV_FWD_LIM] = pin_prev[P_FWD] && !pin_lvl[P_FWD];
    events[`SDIC_EV_REV_LIM] = pin_prev[P_REV] && !pin_lvl[P_REV];
    events[`SDIC_EV_ERR_CLR] = clr_now && !pin_prev[P_CLR];
    next_int_stat = int_stat;
    if (wr_en && paddr == `SDIC_OFS_INT_STAT) begin
      next_int_stat = int_stat & ~pwdata[`SDIC_NUM_EV-1:0];
    end
    next_int_stat = next_int_stat | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
      irq <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq <= |(next_int_stat & int_mask);
    end
  end

  // ----------------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (paddr)
      `SDIC_OFS_CFG: begin
        rd_word[`SDIC_CFG_MP_LSB +: 3] = mp_sel;
        rd_word[`SDIC_CFG_MODE_LSB +: 2] = ctrl_mode;
        rd_word[`SDIC_CFG_ALT_LSB +: 2] = alt_mode;
        rd_word[`SDIC_CFG_TL_BIT] = tl_sel;
        rd_word[`SDIC_CFG_ZCLAMP_BIT] = zclamp_en;
        rd_word[`SDIC_CFG_REGEN_BIT] = regen_internal_sel;
      end
      `SDIC_OFS_ALLOC_A: rd_word[`SDIC_ALLOC_LSB +: `SDIC_ALLOC_W] = alloc_a;
      `SDIC_OFS_ALLOC_B: rd_word[`SDIC_ALLOC_LSB +: `SDIC_ALLOC_W] = alloc_b;
      `SDIC_OFS_STATUS: begin
        rd_word[NPIN-1:0] = pin_lvl;
        rd_word[`SDIC_STAT_ALARM_BIT] = alarm_active;
        rd_word[`SDIC_STAT_SERVO_BIT] = servo_enabled;
        rd_word[`SDIC_STAT_MODE_LSB +: 2] = active_mode;
      end
      `SDIC_OFS_ERRCNT: rd_word[ERR_W-1:0] = position_error;
      `SDIC_OFS_INT_STAT: rd_word[`SDIC_NUM_EV-1:0] = int_stat;
      `SDIC_OFS_INT_MASK: rd_word[`SDIC_NUM_EV-1:0] = int_mask;
      default: rd_ok = 1'b0;
    endcase
  end

  // Data is caught in the setup cycle, so every access takes two cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      if (psel && !penable) begin
        prdata <= (pwrite || !rd_ok) ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pctrl_loop: assert property (
    mp_is(SDIC_MP_PCTRL) && mp_on |=> speed_loop_p_only)
    else $error("P-only loop not selected");
  a_dir_reverse: assert property (
    dir_reversed |-> $past(mp_is(SDIC_MP_DIR) && tl_sel == SDIC_TL_INTSPD &&
                           mp_on))
    else $error("direction reversed without cause");
  a_mode_switch: assert property (
    !mp_is(SDIC_MP_MODESW) ##1 !mp_is(SDIC_MP_MODESW)
      |-> active_mode == $past(ctrl_mode))
    else $error("mode changed without switch input");
  a_zero_clamp: assert property (
    speed_ref_zero |-> $past(mode_now == SDIC_SPEED && zclamp_en))
    else $error("zero clamp outside speed mode");
  a_pulse_block: assert property (
    pin_block && !fb_step && !clr_now |=> $stable(position_error))
    else $error("reference pulse taken while blocked");
  a_limit_stop: assert property (
    !pin_lvl[P_FWD] |=> !fwd_run_allow)
    else $error("forward run allowed with limit off");
  a_torque_clamp: assert property (
    tl_sel == SDIC_TL_EXT && pin_lvl[P_NCL] |=> rev_current_limit)
    else $error("reverse current limit missing");
  a_speed_select: assert property (
    tl_sel == SDIC_TL_EXT |=> int_speed_sel == 2'h0)
    else $error("speed select active in torque limit use");
  a_alarm_release: assert property (
    pin_lvl[P_ALM] && !pin_prev[P_ALM] && !fault_event |=> !alarm_active)
    else $error("alarm not released");
  a_err_clear: assert property (
    clr_now |=> position_error == '0)
    else $error("error count not cleared");
  a_homing_edge: assert property (
    homing_start |-> $past(hom_lvl) && !$past(hom_prev))
    else $error("homing start without rising edge");
  a_zero_level: assert property (
    zero_lvl [*2] |-> zero_position)
    else $error("zero position not asserted");
  a_one_function: assert property (
    $onehot0({speed_loop_p_only, dir_reversed, speed_ref_zero, pulse_inhibit}))
    else $error("two multi-purpose functions active");

  c_homing: cover property (hom_lvl && !hom_prev ##1 homing_start);
  c_alarm_cycle: cover property (
    $rose(alarm_active) ##[1:50] $fell(alarm_active));
  c_irq: cover property ($rose(irq));
  c_apb_read: cover property (psel && penable && pready && !pwrite);
endmodule : sdic_input_control
`default_nettype wire

// ### verilog/sdic_params.svh
// Register offsets, field positions, reset values and counts of the
// servo drive input control block.
// Assumes it is included by name from the design files and the bench.
`ifndef SDIC_PARAMS_SVH
`define SDIC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SDIC_OFS_CFG 8'h00
`define SDIC_OFS_ALLOC_A 8'h04
`define SDIC_OFS_ALLOC_B 8'h08
`define SDIC_OFS_STATUS 8'h0C
`define SDIC_OFS_ERRCNT 8'h10
`define SDIC_OFS_INT_STAT 8'h14
`define SDIC_OFS_INT_MASK 8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SDIC_CFG_MP_LSB 0
`define SDIC_CFG_MODE_LSB 3
`define SDIC_CFG_ALT_LSB 5
`define SDIC_CFG_TL_BIT 7
`define SDIC_CFG_ZCLAMP_BIT 8
`define SDIC_CFG_REGEN_BIT 9
`define SDIC_ALLOC_LSB 0
`define SDIC_STAT_ALARM_BIT 16
`define SDIC_STAT_SERVO_BIT 17
`define SDIC_STAT_MODE_LSB 18
`define SDIC_EV_FAULT 0
`define SDIC_EV_ALM_REL 1
`define SDIC_EV_HOMING 2
`define SDIC_EV_FWD_LIM 3
`define SDIC_EV_REV_LIM 4
`define SDIC_EV_ERR_CLR 5

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SDIC_REGEN_RST 1'b1
`define SDIC_ALLOC_RST 3'h0
`define SDIC_NUM_EV 6
`define SDIC_ALLOC_W 3

`endif

// ### verilog/sdic_pkg.sv
// Types shared by the servo drive input control design.
// Assumes nothing of its surroundings.
package sdic_pkg;

  // Function given to the multi-purpose input.
  typedef enum logic [2:0] {
    SDIC_MP_PCTRL = 3'h0,
    SDIC_MP_DIR = 3'h1,
    SDIC_MP_ZCLAMP = 3'h3,
    SDIC_MP_MODESW = 3'h2,
    SDIC_MP_PINH = 3'h6
  } sdic_mp_func_t;

  // Control mode of the drive.
  typedef enum logic [1:0] {
    SDIC_SPEED = 2'h0,
    SDIC_POSITION = 2'h1,
    SDIC_TORQUE = 2'h3
  } sdic_mode_t;

  // Use of the torque-limit input pair.
  typedef enum logic {
    SDIC_TL_EXT = 1'b0,
    SDIC_TL_INTSPD = 1'b1
  } sdic_tl_func_t;

endpackage : sdic_pkg
